// file: common/basic_timer_consts.vh
`ifndef BASIC_TIMER_CONSTS_VH
`define BASIC_TIMER_CONSTS_VH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define BT_CONTROL_OFFSET 8'hD3
`define BT_COUNT_OFFSET 8'hD4
`define BT_STATUS_OFFSET 8'hD5
// ----------------------------------------
// control register fields
// ----------------------------------------
`define BT_CONTROL_RESET 8'h00
`define BT_WD_CODE_MSB 7
`define BT_WD_CODE_LSB 4
`define BT_WD_DISABLE_CODE 4'hA
`define BT_CLKSEL_MSB 3
`define BT_CLKSEL_LSB 2
`define BT_CNT_CLEAR_BIT 1
`define BT_DIV_CLEAR_BIT 0
// ----------------------------------------
// clock selection encodings and ratios
// ----------------------------------------
`define BT_SEL_DIV4096 2'h0
`define BT_SEL_DIV1024 2'h1
`define BT_SEL_DIV128 2'h2
`define BT_SEL_INVALID 2'h3
`define BT_DIV_WIDTH 12
`endif

// file: hdl/basic_counter.v
`default_nettype none
`include "basic_timer_consts.vh"
// eight bit up counter advanced by a one-cycle tick
module basic_counter #(
	parameter WIDTH = 8
) (
	input wire clk_i,
	input wire rst_i,
	input wire clear_i, // synchronous clear
	input wire tick_i, // advance one step
	output reg [WIDTH-1:0] count_o, // current count
	output reg overflow_o // pulse on wrap to zero
);
	// ----------------------------------------
	// counter
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			count_o <= {WIDTH{1'b0}};
			overflow_o <= 1'b0;
		end else begin
			overflow_o <= tick_i && (&count_o);
			if (tick_i) begin
				count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // basic_counter
`default_nettype wire

// file: hdl/basic_timer_control.v
// The Wishbone register port was left to the implementer.
`default_nettype none
`include "basic_timer_consts.vh"
module basic_timer_control #(
	parameter DIV_WIDTH = `BT_DIV_WIDTH,
	parameter CNT_WIDTH = 8
) (
	input wire clk_i,
	input wire rst_i,
	// classic wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	output wire err_o,
	// block outputs
	output wire watchdog_enable_o,
	output wire bt_tick_o,
	output wire [DIV_WIDTH-1:0] prescaler_o,
	output wire [CNT_WIDTH-1:0] bt_count_o,
	output wire bt_overflow_o
);
	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	// one-hot address match, used by ack and err; the read mux decodes adr_i itself
	function is_mapped;
		input [7:0] a;
		begin
			is_mapped = (a == `BT_CONTROL_OFFSET) || (a == `BT_COUNT_OFFSET) ||
				(a == `BT_STATUS_OFFSET);
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [3:0] wd_code; // watchdog disable code
	reg [1:0] clk_sel; // basic timer clock selection
	reg cnt_clear; // pending counter clear command
	reg div_clear; // pending divider clear command
	reg ack; // single cycle acknowledge
	reg [DIV_WIDTH-1:0] div_prev; // last divider value for edge detection
	reg tick; // registered selected tick
	wire req; // valid bus cycle this clock
	wire wr_ctrl; // write hits control byte lane 0
	wire [DIV_WIDTH-1:0] div; // prescaler chain
	reg sel_bit_now; // selected divider bit now
	reg sel_bit_prev; // selected divider bit last cycle

	assign req = cyc_i && stb_i && !ack;
	// ack one cycle after the request, never back to back
	assign ack_o = ack && is_mapped(adr_i);
	assign err_o = ack && !is_mapped(adr_i);
	assign wr_ctrl = req && we_i && sel_i[0] && (adr_i == `BT_CONTROL_OFFSET);

	// ----------------------------------------
	// bus acknowledge
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// write takes effect at the request edge so the answer edge sees it stored
	always @(posedge clk_i) begin
		if (rst_i) begin
			wd_code <= 4'h0;
			clk_sel <= 2'h0;
			cnt_clear <= 1'b0;
			div_clear <= 1'b0;
		end else begin
			// command bits live one cycle, then drop by themselves
			cnt_clear <= 1'b0;
			div_clear <= 1'b0;
			if (wr_ctrl) begin
				wd_code <= dat_i[`BT_WD_CODE_MSB:`BT_WD_CODE_LSB];
				clk_sel <= dat_i[`BT_CLKSEL_MSB:`BT_CLKSEL_LSB];
				// only a one fires; zero leaves counter alone
				cnt_clear <= dat_i[`BT_CNT_CLEAR_BIT];
				// only a one fires; zero leaves dividers alone
				div_clear <= dat_i[`BT_DIV_CLEAR_BIT];
			end
		end
	end

	// any code but 1010 keeps the watchdog armed
	assign watchdog_enable_o = (wd_code != `BT_WD_DISABLE_CODE);

	// ----------------------------------------
	// shared prescaler
	// ----------------------------------------
	freq_divider #(
		.WIDTH(DIV_WIDTH)
	) u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(div_clear),
		.div_o(div)
	);
	assign prescaler_o = div;

	// ----------------------------------------
	// clock selection
	// ----------------------------------------
	// falling edge of divider bit n marks one period of fxx/2^(n+1)
	always @* begin
		sel_bit_now = 1'b0;
		sel_bit_prev = 1'b0;
		case (clk_sel)
			`BT_SEL_DIV4096: begin
				sel_bit_now = div[11];
				sel_bit_prev = div_prev[11];
			end
			`BT_SEL_DIV1024: begin
				sel_bit_now = div[9];
				sel_bit_prev = div_prev[9];
			end
			`BT_SEL_DIV128: begin
				sel_bit_now = div[6];
				sel_bit_prev = div_prev[6];
			end
			default: begin
				// invalid selection: no clock reaches the counter
				sel_bit_now = 1'b0;
				sel_bit_prev = 1'b0;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			div_prev <= {DIV_WIDTH{1'b0}};
			tick <= 1'b0;
		end else begin
			div_prev <= div;
			tick <= sel_bit_prev && !sel_bit_now;
		end
	end
	assign bt_tick_o = tick;

	// ----------------------------------------
	// basic timer counter
	// ----------------------------------------
	basic_counter #(
		.WIDTH(CNT_WIDTH)
	) u_cnt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(cnt_clear),
		.tick_i(tick),
		.count_o(bt_count_o),
		.overflow_o(bt_overflow_o)
	);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// command bits read back as zero once done
	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (req) begin
			case (adr_i)
				`BT_CONTROL_OFFSET: dat_o <= {24'h000000, wd_code, clk_sel, 2'h0};
				`BT_COUNT_OFFSET: dat_o <= {{(32-CNT_WIDTH){1'b0}}, bt_count_o};
				`BT_STATUS_OFFSET: dat_o <= {31'h00000000, watchdog_enable_o};
				default: dat_o <= 32'h00000000;
			endcase
		end
	end
endmodule // basic_timer_control
`default_nettype wire

// file: hdl/freq_divider.v
`default_nettype none
`include "basic_timer_consts.vh"
// free running prescaler shared by basic timer and timer counters
module freq_divider #(
	parameter WIDTH = `BT_DIV_WIDTH
) (
	input wire clk_i,
	input wire rst_i,
	input wire clear_i, // synchronous clear of the whole chain
	output reg [WIDTH-1:0] div_o // divider chain, bit n toggles at fxx/2^(n+1)
);
	// ----------------------------------------
	// divider chain
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			div_o <= {WIDTH{1'b0}};
		end else begin
			div_o <= div_o + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // freq_divider
`default_nettype wire

// file: testbench/bt_ctrl_asserts.sv
`default_nettype none
// ------------------------
// control block checker
// ------------------------
module bt_ctrl_asserts #(parameter DIV_WIDTH = 12, parameter CNT_WIDTH = 8) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic watchdog_enable_o,
	input wire logic bt_tick_o,
	input wire logic [DIV_WIDTH-1:0] prescaler_o,
	input wire logic [CNT_WIDTH-1:0] bt_count_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// fresh request to the control register
	sequence s_req;
		cyc_i && stb_i && !ack_o && adr_i == 8'hD3;
	endsequence
	sequence s_wr;
		s_req ##0 (we_i && sel_i[0]);
	endsequence
	a_wd_code: assert property (s_wr ##1 ack_o |-> watchdog_enable_o == ($past(dat_i[7:4]) != 4'hA))
		else $error("watchdog enable wrong");
	a_tick_phase: assert property (bt_tick_o |-> prescaler_o[6:0] inside {7'h01, 7'h02})
		else $error("tick off divider edge");
	a_count_clear: assert property (s_wr ##0 dat_i[1] |-> ##2 bt_count_o == '0)
		else $error("count not cleared");
	a_div_clear: assert property (s_wr ##0 dat_i[0] |-> ##2 prescaler_o == '0)
		else $error("divider not cleared");
	a_cmd_reads0: assert property (s_req ##0 !we_i ##1 ack_o |-> dat_o[1:0] == 2'h0)
		else $error("command bits stuck");
	a_div_kept: assert property (s_wr ##0 !dat_i[0] |-> ##2 prescaler_o == $past(prescaler_o, 2) + 2'd2)
		else $error("divider disturbed");
endmodule // bt_ctrl_asserts
bind basic_timer_control bt_ctrl_asserts #(.DIV_WIDTH(DIV_WIDTH), .CNT_WIDTH(CNT_WIDTH)) chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .watchdog_enable_o(watchdog_enable_o),
	.bt_tick_o(bt_tick_o), .prescaler_o(prescaler_o), .bt_count_o(bt_count_o));
`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0] adr_i = 8'h00, bt_count_o;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic ack_o, err_o, watchdog_enable_o, bt_tick_o, e;
	logic [11:0] prescaler_o;
	int n_fail = 0, checks = 0, cycles = 0, p;
	int divs[3] = '{4096, 1024, 128}; // expected tick periods
	basic_timer_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.watchdog_enable_o(watchdog_enable_o), .bt_tick_o(bt_tick_o), .prescaler_o(prescaler_o),
		.bt_count_o(bt_count_o), .bt_overflow_o());
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic print_verdict;
		if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; wait for ack or err, then idle a cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
		rd = dat_o;
		e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// cycles between two ticks
	task automatic period;
		p = 0;
		while (bt_tick_o !== 1'b1) @(posedge clk_i);
		do begin
			@(posedge clk_i);
			p++;
		end while (bt_tick_o !== 1'b1);
	endtask
	// hang guard, well above the ~11k cycles of the tests
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			print_verdict;
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'hD3, 32'h0);
		chk(rd, 32'h0);
		for (int c = 0; c < 16; c++) begin
			wb(1'b1, 8'hD3, 32'(c << 4));
			chk(watchdog_enable_o, c != 10);
		end
		for (int s = 0; s < 3; s++) begin
			wb(1'b1, 8'hD3, 32'(s << 2));
			period;
			chk(p, divs[s]);
		end
		wb(1'b1, 8'hD3, 32'h0C);
		p = 0;
		repeat (300) begin
			@(posedge clk_i);
			p += bt_tick_o;
		end
		chk(p, 0);
		chk(bt_count_o != 0, 1);
		// clear with ticks stopped, so no tick can sneak in before the compare
		wb(1'b1, 8'hD3, 32'h0E);
		chk(bt_count_o, 0);
		wb(1'b0, 8'hD3, 32'h0);
		chk(rd, 32'h0C);
		wb(1'b1, 8'hD3, 32'h08);
		repeat (300) @(posedge clk_i);
		wb(1'b1, 8'hD3, 32'h09);
		chk(prescaler_o < 12'h4, 1);
		chk(bt_count_o != 0, 1);
		wb(1'b1, 8'h10, 32'hFF);
		chk(e, 1);
		wb(1'b0, 8'hD3, 32'h0);
		chk(rd, 32'h08);
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
